// >>> rtl/an_page_regs.v
// Purpose: page exchange status and control registers on axi4-lite
// Assumes: inputs synchronous to core_clk, one write and one read at a time
// Notes: reads of the expansion register clear its latched bits
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "an_page_regs.vh"

module an_page_regs (
   input wire core_clk,
   input wire rst_n,
   input wire [31:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [31:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire base_page_valid,
   input wire [15:0] base_page_word,
   input wire next_page_valid,
   input wire [15:0] next_page_word,
   input wire pd_fault_event,
   input wire partner_np_able,
   input wire partner_an_able,
   input wire link_fail,
   input wire [1:0] tx_ctrl_bits,
   output reg [15:0] tx_code_word,
   output reg page_loaded
);

   reg [15:0] base_page_r;
   reg [15:0] rx_page_r;
   reg [15:0] tx_page_r;
   reg pd_fault_r;
   reg page_rcvd_r;
   reg local_np_r;
   reg aw_held_r;
   reg w_held_r;
   reg [3:0] aw_idx_r;
   reg aw_bad_r;
   reg [31:0] wdata_r;
   reg [3:0] wstrb_r;

   // decode a byte address into a register index; flag unaligned or far
   function [4:0] decode;
      input [31:0] addr;
      begin
         if (addr[1:0] != 2'b00 || addr[31:6] != 26'h0) begin
            decode = {1'b1, 4'h0};
         end else if (addr[5:2] >= `IDX_BASE_PAGE &&
                      addr[5:2] <= `IDX_CONTROL) begin
            decode = {1'b0, addr[5:2]};
         end else begin
            decode = {1'b1, 4'h0};
         end
      end
   endfunction

   wire [4:0] aw_dec = decode(s_axi_awaddr);
   wire [4:0] ar_dec = decode(s_axi_araddr);

   // channels are taken independently; response waits for both
   assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
   assign s_axi_wready = !w_held_r && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;

   wire aw_fire = s_axi_awvalid && s_axi_awready;
   wire w_fire = s_axi_wvalid && s_axi_wready;
   wire ar_fire = s_axi_arvalid && s_axi_arready;
   wire have_aw = aw_held_r || aw_fire;
   wire have_w = w_held_r || w_fire;
   wire wr_go = have_aw && have_w;
   wire [3:0] wr_idx = aw_held_r ? aw_idx_r : aw_dec[3:0];
   wire wr_bad = aw_held_r ? aw_bad_r : aw_dec[4];
   wire [31:0] wr_data = w_held_r ? wdata_r : s_axi_wdata;
   wire [3:0] wr_strb = w_held_r ? wstrb_r : s_axi_wstrb;
   wire [15:0] byte_mask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};
   wire tx_wr = wr_go && !wr_bad && wr_idx == `IDX_TX_PAGE &&
                (wr_strb[1] || wr_strb[0]);
   wire ctrl_wr = wr_go && !wr_bad && wr_idx == `IDX_CONTROL;
   wire soft_reset = ctrl_wr && wr_strb[0] &&
                     wr_data[`CTRL_SOFT_RESET];
   wire exp_read = ar_fire && !ar_dec[4] && ar_dec[3:0] == `IDX_EXPANSION;

   // write address and data latches for the out-of-order case
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         aw_idx_r <= 4'h0;
         aw_bad_r <= 1'b0;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `AXI_RESP_OKAY;
      end else begin
         if (wr_go) begin
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_bad ? `AXI_RESP_SLVERR : `AXI_RESP_OKAY;
         end else begin
            if (aw_fire) begin
               aw_held_r <= 1'b1;
               aw_idx_r <= aw_dec[3:0];
               aw_bad_r <= aw_dec[4];
            end
            if (w_fire) begin
               w_held_r <= 1'b1;
               wdata_r <= s_axi_wdata;
               wstrb_r <= s_axi_wstrb;
            end
            if (s_axi_bvalid && s_axi_bready) begin
               s_axi_bvalid <= 1'b0;
            end
         end
      end
   end

   // received pages; each capture lands with its page received flag
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         base_page_r <= `RX_PAGE_RESET;
         rx_page_r <= `RX_PAGE_RESET;
      end else if (soft_reset) begin
         base_page_r <= `RX_PAGE_RESET;
         rx_page_r <= `RX_PAGE_RESET;
      end else begin
         if (base_page_valid) begin
            base_page_r <= base_page_word;
         end
         if (next_page_valid) begin
            rx_page_r <= next_page_word;
         end
      end
   end

   // latched-high bits: a new event in the read cycle wins over the clear
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pd_fault_r <= 1'b0;
         page_rcvd_r <= 1'b0;
         local_np_r <= `LOCAL_NP_RESET;
      end else if (soft_reset) begin
         pd_fault_r <= 1'b0;
         page_rcvd_r <= 1'b0;
         local_np_r <= `LOCAL_NP_RESET;
      end else begin
         if (pd_fault_event) begin
            pd_fault_r <= 1'b1;
         end else if (exp_read) begin
            pd_fault_r <= 1'b0;
         end
         if (base_page_valid || next_page_valid) begin
            page_rcvd_r <= 1'b1;
         end else if (exp_read) begin
            page_rcvd_r <= 1'b0;
         end
         if (ctrl_wr && wr_strb[0]) begin
            local_np_r <= wr_data[`CTRL_LOCAL_NP];
         end
      end
   end

   // transmit page; link failure restores it, read-only bits are kept
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_page_r <= `TX_PAGE_RESET;
         page_loaded <= 1'b0;
      end else if (soft_reset || link_fail) begin
         tx_page_r <= `TX_PAGE_RESET;
         page_loaded <= 1'b0;
      end else begin
         page_loaded <= tx_wr;
         if (tx_wr) begin
            tx_page_r <= (tx_page_r & ~(byte_mask & `TX_WRITE_MASK)) |
                         (wr_data[15:0] & byte_mask &
                          `TX_WRITE_MASK);
         end
      end
   end

   // code word: software bits plus the ack and toggle bits held by the fsm
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_code_word <= `TX_PAGE_RESET;
      end else begin
         tx_code_word <= {tx_page_r[15], tx_ctrl_bits[1], tx_page_r[13:12],
                          tx_ctrl_bits[0], tx_page_r[10:0]};
      end
   end

   // read data mux; expansion upper bits are reserved zero
   reg [15:0] rd_val;
   always @* begin
      rd_val = 16'h0000;
      case (ar_dec[3:0])
         `IDX_BASE_PAGE: rd_val = base_page_r;
         `IDX_EXPANSION: rd_val = {11'h000, pd_fault_r, partner_np_able,
                                   local_np_r, page_rcvd_r,
                                   partner_an_able};
         `IDX_TX_PAGE: rd_val = {tx_page_r[15], tx_ctrl_bits[1],
                                 tx_page_r[13:12], tx_ctrl_bits[0],
                                 tx_page_r[10:0]};
         `IDX_RX_PAGE: rd_val = rx_page_r;
         `IDX_CONTROL: rd_val = {14'h0000, local_np_r, 1'b0};
         default: rd_val = 16'h0000;
      endcase
   end

   // read channel; one cycle from address to data
   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `AXI_RESP_OKAY;
      end else if (ar_fire) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= ar_dec[4] ? 32'h0000_0000 : {16'h0000, rd_val};
         s_axi_rresp <= ar_dec[4] ? `AXI_RESP_SLVERR : `AXI_RESP_OKAY;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule

// >>> rtl/an_page_regs.vh
// Purpose: register map and field constants for the page exchange registers
// Assumes: 32-bit axi4-lite data, 16-bit registers in the low half
// Notes: printed offsets are indices; byte address is four times the index
`ifndef AN_PAGE_REGS_VH
`define AN_PAGE_REGS_VH

`define IDX_BASE_PAGE 4'h5
`define IDX_EXPANSION 4'h6
`define IDX_TX_PAGE 4'h7
`define IDX_RX_PAGE 4'h8
`define IDX_CONTROL 4'h9

`define EXP_PD_FAULT 4
`define EXP_PARTNER_NP 3
`define EXP_LOCAL_NP 2
`define EXP_PAGE_RCVD 1
`define EXP_PARTNER_AN 0

`define TX_WRITE_MASK 16'hb7ff
`define TX_PAGE_RESET 16'h2001
`define RX_PAGE_RESET 16'h0000
`define LOCAL_NP_RESET 1'b1
`define CTRL_SOFT_RESET 0
`define CTRL_LOCAL_NP 1

`define AXI_RESP_OKAY 2'b00
`define AXI_RESP_SLVERR 2'b10

`endif

// >>> testbench/an_page_regs_tb_top.sv
// Purpose: random and corner stimulus for the page registers
// Assumes: the master waits for every answer
// Notes: expected words are built from sent and written values
`timescale 1ns/1ps
`include "an_page_regs.vh"
module an_page_regs_tb_top;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_rdata, seed = 32'h4b94, r;
   logic [3:0] s_axi_wstrb = 4'hf;
   // answers are always accepted, so ready never toggles between transfers
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b1;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, page_loaded, base_page_valid, next_page_valid;
   logic pd_fault_event, partner_np_able, partner_an_able, link_fail;
   logic [1:0] s_axi_bresp, s_axi_rresp, tx_ctrl_bits;
   logic [15:0] base_page_word, next_page_word, tx_code_word;
   int err_count = 0, total_checks = 0, cycles = 0;
   an_page_regs dut (.*);
   nego_peer peer (.*);
   always #5 core_clk = ~core_clk;
   // hang guard
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 5000) begin
         err_count++;
         tally_and_finish;
      end
   end
   function logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function logic [31:0] tx_exp(input logic [15:0] d, input logic [1:0] c);
      return {16'h0, d & `TX_WRITE_MASK | {1'b0, c[1], 2'h0, c[0], 11'h0}};
   endfunction
   function logic [31:0] ex_exp(input logic pr, input logic [3:0] f,
                                input logic pd);
      return {27'h0, pd, f[3], 1'b1, pr, f[2]};
   endfunction
   task chk(input logic [31:0] got, exp);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // handshakes are judged on settled values before the edge, not racing it
   task wr(input logic [31:0] a, d);
      logic aw_ok, w_ok, b_ok;
      logic [1:0] resp;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      b_ok = 1'b0;
      while (!b_ok) begin
         #1;
         aw_ok = s_axi_awvalid && s_axi_awready;
         w_ok = s_axi_wvalid && s_axi_wready;
         b_ok = s_axi_bvalid;
         resp = s_axi_bresp;
         @(posedge core_clk);
         if (aw_ok) s_axi_awvalid <= 1'b0;
         if (w_ok) s_axi_wvalid <= 1'b0;
      end
      chk(resp, `AXI_RESP_OKAY);
   endtask
   task rd(input logic [31:0] a, exp);
      logic ar_ok, r_ok;
      logic [31:0] data;
      logic [1:0] resp;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      r_ok = 1'b0;
      while (!r_ok) begin
         #1;
         ar_ok = s_axi_arvalid && s_axi_arready;
         r_ok = s_axi_rvalid;
         data = s_axi_rdata;
         resp = s_axi_rresp;
         @(posedge core_clk);
         if (ar_ok) s_axi_arvalid <= 1'b0;
      end
      chk(data, exp);
      chk(resp, (a > 32'h10 && a < 32'h28) ? 2'h0 : 2'h2);
   endtask
   task tally_and_finish;
      if (err_count == 0 && total_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge core_clk);
      rst_n <= 1'b1;
      rd(32'h14, 32'h0);
      rd(32'h18, 32'h4);
      rd(32'h1c, 32'h2001);
      rd(32'h20, 32'h0);
      rd(32'h40, 32'h0);
      for (int i = 0; i < 8; i++) begin
         r = xs();
         peer.flags(r[3:0]);
         peer.send(r[4], r[31:16]);
         rd(r[4] ? 32'h20 : 32'h14, r[31:16]);
         rd(32'h18, ex_exp(1'b1, r[3:0], 1'b0));
         rd(32'h18, ex_exp(1'b0, r[3:0], 1'b0));
         wr(32'h1c, r);
         rd(32'h1c, tx_exp(r[15:0], r[1:0]));
         chk(tx_code_word, tx_exp(r[15:0], r[1:0]));
      end
      peer.fault(1'b0);
      rd(32'h18, ex_exp(1'b0, r[3:0], 1'b1));
      rd(32'h18, ex_exp(1'b0, r[3:0], 1'b0));
      peer.fault(1'b1);
      rd(32'h1c, tx_exp(16'h2001, r[1:0]));
      wr(32'h24, 32'h1);
      rd(r[4] ? 32'h20 : 32'h14, 32'h0);
      tally_and_finish;
   end
endmodule

// >>> testbench/nego_peer.sv
// Purpose: negotiation side feeding pages, faults and flags
// Assumes: changes right after a rising edge
// Notes: a released word shows its inverse, never a stale copy
`timescale 1ns/1ps
module nego_peer (
   input wire core_clk,
   output logic base_page_valid = 1'b0,
   output logic [15:0] base_page_word = 16'h0,
   output logic next_page_valid = 1'b0,
   output logic [15:0] next_page_word = 16'h0,
   output logic pd_fault_event = 1'b0,
   output logic partner_np_able = 1'b0,
   output logic partner_an_able = 1'b0,
   output logic link_fail = 1'b0,
   output logic [1:0] tx_ctrl_bits = 2'h0
);
   // one-cycle page strobe, word scrambled once released
   task send(input logic nxt, input logic [15:0] w);
      @(posedge core_clk);
      base_page_valid <= !nxt;
      next_page_valid <= nxt;
      base_page_word <= w;
      next_page_word <= w;
      @(posedge core_clk);
      base_page_valid <= 1'b0;
      next_page_valid <= 1'b0;
      base_page_word <= ~w;
      next_page_word <= ~w;
   endtask
   task fault(input logic lf);
      @(posedge core_clk);
      pd_fault_event <= !lf;
      link_fail <= lf;
      repeat (3) @(posedge core_clk);
      pd_fault_event <= 1'b0;
      link_fail <= 1'b0;
   endtask
   task flags(input logic [3:0] f);
      @(posedge core_clk);
      {partner_np_able, partner_an_able, tx_ctrl_bits} <= f;
   endtask
endmodule

// >>> testbench/page_chk_sva.sv
// Purpose: bus handshake and transmit word checks
// Assumes: aw and w are offered together
// Notes: register contents are judged by the bench reads
`timescale 1ns/1ps
`include "an_page_regs.vh"
module page_chk (
   input wire core_clk,
   input wire rst_n,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0] s_axi_rresp,
   input wire page_loaded,
   input wire link_fail,
   input wire [1:0] tx_ctrl_bits,
   input wire [15:0] tx_code_word
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // the loaded flag rides with the write answer, one cycle only
   property p_loaded; page_loaded |-> $rose(s_axi_bvalid) ##1 !page_loaded; endproperty
   a_loaded: assert property (p_loaded) else $error("loaded flag");
   property p_lfail; link_fail ##1 link_fail |=> (tx_code_word & `TX_WRITE_MASK) == `TX_PAGE_RESET; endproperty
   a_lfail: assert property (p_lfail) else $error("link fail word");
   property p_robits; $stable(tx_ctrl_bits) |=> {tx_code_word[14], tx_code_word[11]} == $past(tx_ctrl_bits); endproperty
   a_robits: assert property (p_robits) else $error("fsm bits");
   property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
   a_bhold: assert property (p_bhold) else $error("write answer dropped");
   property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
   a_rhold: assert property (p_rhold) else $error("read answer dropped");
   property p_arrdy; s_axi_arready == !s_axi_rvalid; endproperty
   a_arrdy: assert property (p_arrdy) else $error("arready");
   property p_rans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
   a_rans: assert property (p_rans) else $error("late read answer");
   property p_slv; s_axi_rvalid && s_axi_rresp == `AXI_RESP_SLVERR |-> s_axi_rdata == 32'h0; endproperty
   a_slv: assert property (p_slv) else $error("error read data");
endmodule
bind an_page_regs page_chk chk (.*);
